// [shared/pif_pkg.sv]
package pif_pkg;
    // register map, word indices on the plain port
    localparam int PIF_ADDR_W = 4;
    localparam logic [3:0] PIF_ADDR_TIMER = 4'h0;
    localparam logic [3:0] PIF_ADDR_CHAN = 4'h1;
    localparam logic [3:0] PIF_ADDR_MASK = 4'h2;
    localparam logic [3:0] PIF_ADDR_STAT = 4'h3;
    localparam logic [3:0] PIF_ADDR_MODE = 4'h4;
    // field positions
    localparam int PIF_BIT_FIRST = 0;
    localparam int PIF_BIT_SECOND = 1;
    localparam int PIF_NFLAGS = 2;
    // reset values
    localparam logic [7:0] PIF_RST_FLAGS = 8'h00;
    localparam logic [3:0] PIF_RST_MASK = 4'h0;
    localparam logic [1:0] PIF_RST_MODE = 2'h0;
    // channel mode select encoding
    localparam logic [1:0] PIF_MODE_CAPTURE = 2'h0;
    localparam logic [1:0] PIF_MODE_COMPARE = 2'h1;
    localparam logic [1:0] PIF_MODE_PWM = 2'h2;
endpackage

// [rtl/pif_flags.sv]
`timescale 1ns/100ps
// How it works
// - second timer flag sets on postscaler overflow, or period match at 1:1.
// - first timer flag sets on 16-bit counter overflow, held until cleared.
// - second channel flag sets on capture event in capture mode.
// - second channel flag sets on compare match in compare mode.
// - second channel flag sets on PWM trailing edge in PWM mode.
// - flags set regardless of enables; enables gate only the request.
// - bits 7..2 of both flag registers ignore writes, read zero.
// - flags readable, writable, hardware set, zero after every reset.
// - first channel flag behaves like the second, per its own mode.
module pif_flags
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [pif_pkg::PIF_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_timer1_overflow,
    input wire logic i_timer2_postscale_ovf,
    input wire logic i_timer2_period_match,
    input wire logic i_timer2_ratio_one,
    input wire logic [1:0] i_chan_capture,
    input wire logic [1:0] i_chan_compare,
    input wire logic [1:0] i_chan_pwm_fall,
    input wire logic i_global_interrupt_enable,
    output logic o_irq
);
    import pif_pkg::*;

    // flag storage: only the two low bits of each register exist;
    // the upper six bits are not stored, which is why they read zero
    logic [PIF_NFLAGS-1:0] timer_event_flags;
    logic [PIF_NFLAGS-1:0] capture_compare_event_flags;

    // next values of the flag registers
    logic [PIF_NFLAGS-1:0] next_timer_event_flags;
    logic [PIF_NFLAGS-1:0] next_capture_compare_event_flags;

    // mask and sticky status share one layout: {chan1, chan0, timer2, timer1}
    logic [3:0] irq_mask;
    logic [3:0] irq_status;
    logic [3:0] next_irq_status;

    // unmasked pending events and their summary
    logic [3:0] irq_pending;
    logic irq_any;

    // per-channel event selection, two bits each
    logic [1:0] channel_mode_select [PIF_NFLAGS];

    // hardware set requests, each one cycle wide
    logic timer2_event;
    logic [PIF_NFLAGS-1:0] timer_set;
    logic [PIF_NFLAGS-1:0] chan_set;
    logic [3:0] all_set;

    // decoded bus strobes
    logic wr_timer;
    logic wr_chan;
    logic wr_mask;
    logic wr_mode;
    logic rd_stat;

    // readable words, already zero-extended to the bus width
    logic [7:0] timer_word;
    logic [7:0] chan_word;
    logic [7:0] mask_word;
    logic [7:0] stat_word;
    logic [7:0] mode_word;

    // read data before its output register
    logic [7:0] next_rdata;

    // register strobes; an unmapped index matches none of them,
    // so such a write is dropped with no side effect
    assign wr_timer = i_wr && (i_addr == PIF_ADDR_TIMER);
    assign wr_chan = i_wr && (i_addr == PIF_ADDR_CHAN);
    assign wr_mask = i_wr && (i_addr == PIF_ADDR_MASK);
    assign wr_mode = i_wr && (i_addr == PIF_ADDR_MODE);
    assign rd_stat = i_rd && (i_addr == PIF_ADDR_STAT);

    // second timer event: at a one-to-one ratio the postscaler is
    // bypassed, so the period match stands in for its overflow
    always_comb
    begin
        if (i_timer2_ratio_one)
        begin
            timer2_event = i_timer2_period_match;
        end
        else
        begin
            timer2_event = i_timer2_postscale_ovf;
        end
    end

    // timer set requests; pulses are taken as they arrive, no buffering
    assign timer_set[PIF_BIT_FIRST] = i_timer1_overflow;
    assign timer_set[PIF_BIT_SECOND] = timer2_event;

    // per-channel logic: event select and that channel's mode field
    genvar g;
    generate
        for (g = 0; g < PIF_NFLAGS; g++)
        begin : g_chan
            logic pick_capture;
            logic pick_compare;
            logic pick_pwm;

            // mode decode; the fourth code picks nothing, so stray
            // pulses on an unused channel never set its flag
            assign pick_capture = (channel_mode_select[g] == PIF_MODE_CAPTURE);
            assign pick_compare = (channel_mode_select[g] == PIF_MODE_COMPARE);
            assign pick_pwm = (channel_mode_select[g] == PIF_MODE_PWM);

            // only the event that belongs to the current mode counts
            assign chan_set[g] = (pick_capture && i_chan_capture[g])
                || (pick_compare && i_chan_compare[g])
                || (pick_pwm && i_chan_pwm_fall[g]);

            // mode field of this channel; a new mode applies from the cycle
            // after the write, an event in the write cycle uses the old one
            always_ff @(posedge i_clock)
            begin
                if (!i_nrst)
                begin
                    channel_mode_select[g] <= PIF_RST_MODE;
                end
                else if (wr_mode)
                begin
                    channel_mode_select[g] <= i_wdata[2*g +: 2];
                end
            end
        end
    endgenerate

    // timer flags next value: a write loads the live bits and any set
    // event is ored on top, so a clear in the same cycle never loses it;
    // the interrupt enables are deliberately not looked at here
    always_comb
    begin
        if (wr_timer)
        begin
            next_timer_event_flags = i_wdata[PIF_NFLAGS-1:0] | timer_set;
        end
        else
        begin
            next_timer_event_flags = timer_event_flags | timer_set;
        end
    end

    // timer flag register, cleared by every reset;
    // software may also write ones to raise a flag by hand
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            timer_event_flags <= PIF_RST_FLAGS[PIF_NFLAGS-1:0];
        end
        else
        begin
            timer_event_flags <= next_timer_event_flags;
        end
    end

    // channel flags next value, same set-dominant scheme as the timers
    always_comb
    begin
        if (wr_chan)
        begin
            next_capture_compare_event_flags = i_wdata[PIF_NFLAGS-1:0] | chan_set;
        end
        else
        begin
            next_capture_compare_event_flags = capture_compare_event_flags | chan_set;
        end
    end

    // channel flag register, cleared by every reset;
    // a flag stays up until software writes it low
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            capture_compare_event_flags <= PIF_RST_FLAGS[PIF_NFLAGS-1:0];
        end
        else
        begin
            capture_compare_event_flags <= next_capture_compare_event_flags;
        end
    end

    // interrupt mask; software writes it,
    // nothing in hardware ever touches it
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            irq_mask <= PIF_RST_MASK;
        end
        else if (wr_mask)
        begin
            irq_mask <= i_wdata[3:0];
        end
    end

    // all set events in status layout
    assign all_set = {chan_set, timer_set};

    // sticky status, cleared by its own read; an event landing in the
    // read cycle survives so that the next read still reports it
    always_comb
    begin
        if (rd_stat)
        begin
            next_irq_status = all_set;
        end
        else
        begin
            next_irq_status = irq_status | all_set;
        end
    end

    // status register
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            irq_status <= PIF_RST_MASK;
        end
        else
        begin
            irq_status <= next_irq_status;
        end
    end

    // readable words; unused upper bits are tied to zero here
    // so the read mux below only has to pick one
    assign timer_word = {6'h00, timer_event_flags};
    assign chan_word = {6'h00, capture_compare_event_flags};
    assign mask_word = {4'h0, irq_mask};
    assign stat_word = {4'h0, irq_status};
    assign mode_word = {4'h0, channel_mode_select[1], channel_mode_select[0]};

    // read mux; unmapped indices and idle cycles give zero,
    // which keeps the bus quiet outside the answer cycle
    always_comb
    begin
        next_rdata = 8'h00;
        if (i_rd)
        begin
            case (i_addr)
                PIF_ADDR_TIMER: next_rdata = timer_word;
                PIF_ADDR_CHAN: next_rdata = chan_word;
                PIF_ADDR_MASK: next_rdata = mask_word;
                PIF_ADDR_STAT: next_rdata = stat_word;
                PIF_ADDR_MODE: next_rdata = mode_word;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // read data register: stands in the cycle after the strobe only;
    // the master never waits, so no ready signal is needed
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            o_rdata <= 8'h00;
        end
        else
        begin
            o_rdata <= next_rdata;
        end
    end

    // unmasked pending events
    assign irq_pending = irq_status & irq_mask;
    assign irq_any = |irq_pending;

    // request needs the global enable; flags themselves are never gated,
    // so an unread status bit fires at once when its enable is raised
    always_comb
    begin
        if (i_global_interrupt_enable)
        begin
            o_irq = irq_any;
        end
        else
        begin
            o_irq = 1'b0;
        end
    end

endmodule // pif_flags

// [testbench/pif_flags_properties.sv]
`timescale 1ns/100ps
module pif_flags_properties
(
    input logic i_clock, i_nrst, i_wr, i_rd, i_global_interrupt_enable, o_irq,
    input logic i_timer1_overflow, i_timer2_postscale_ovf, i_timer2_period_match,
    input logic i_timer2_ratio_one,
    input logic [3:0] i_addr,
    input logic [7:0] i_wdata, o_rdata
);
    // flag register reads and the active second timer event
    wire rt = i_rd && i_addr == 4'h0;
    wire rc = i_rd && i_addr == 4'h1;
    wire t2 = i_timer2_ratio_one ? i_timer2_period_match : i_timer2_postscale_ovf;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    rd_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata busy");
    hi_zero_a: assert property ($past(rt || rc) |-> o_rdata[7:2] == 6'h00)
        else $error("upper bits set");
    t1_set_a: assert property (i_timer1_overflow ##1 rt |=> o_rdata[0])
        else $error("timer1 flag lost");
    t2_set_a: assert property (t2 ##1 rt |=> o_rdata[1]) else $error("timer2 flag lost");
    set_wins_a: assert property ((i_timer1_overflow && i_wr && i_addr == 4'h0) ##2 rt
        |=> o_rdata[0]) else $error("clear beat set");
    hold_flag_a: assert property (rt ##1 (o_rdata[0] && !i_wr) ##1 (!i_wr && rt)
        |=> o_rdata[0]) else $error("flag dropped");
    wr_clear_a: assert property ((i_wr && i_addr == 4'h0 && !i_wdata[0] && !i_timer1_overflow)
        ##1 !i_timer1_overflow ##1 rt |=> !o_rdata[0]) else $error("flag not cleared");
    gie_gate_a: assert property (!i_global_interrupt_enable |-> !o_irq) else $error("irq ungated");
    cover property (o_irq);
    cover property (rc ##1 o_rdata[1:0] == 2'h3);
    cover property (rt ##1 o_rdata[1]);
endmodule // pif_flags_properties
bind pif_flags pif_flags_properties chk_u (.*);

// [testbench/pif_src.sv]
`timescale 1ns/100ps
module pif_src
(
    input wire logic i_clock,
    output logic [8:0] o_ev
);
    // event lines idle low; a pulse spans exactly one cycle
    initial o_ev = 9'h000;
    task automatic fire(input logic [8:0] ev);
        o_ev <= ev;
        @(posedge i_clock);
        o_ev <= 9'h000;
    endtask
endmodule // pif_src

// [testbench/pif_flags_tb_top.sv]
`timescale 1ns/100ps
module pif_flags_tb_top;
    import pif_pkg::*;
    typedef struct packed {logic r1; logic [8:0] ev; logic [3:0] md, ad; logic [7:0] ex;} pif_row_s;
    logic i_clock, i_nrst, i_wr, i_rd, i_timer2_ratio_one, i_global_interrupt_enable;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, q;
    wire [7:0] o_rdata;
    wire o_irq;
    wire [8:0] ev;
    int num_errors, check_count;
    // ev bits: t1 ovf, t2 post, t2 match, capture[1:0], compare[1:0], pwm[1:0]
    pif_row_s rows [9] = '{'{0, 9'h001, 4'h0, 4'h0, 8'h01}, '{0, 9'h002, 4'h0, 4'h0, 8'h02},
        '{0, 9'h004, 4'h0, 4'h0, 8'h00}, '{1, 9'h004, 4'h0, 4'h0, 8'h02},
        '{1, 9'h002, 4'h0, 4'h0, 8'h00}, '{0, 9'h018, 4'h0, 4'h1, 8'h03},
        '{0, 9'h060, 4'h5, 4'h1, 8'h03}, '{0, 9'h180, 4'ha, 4'h1, 8'h03},
        '{0, 9'h078, 4'ha, 4'h1, 8'h00}};
    pif_src src_u (.i_clock(i_clock), .o_ev(ev));
    pif_flags dut_u (.*, .i_timer1_overflow(ev[0]), .i_timer2_postscale_ovf(ev[1]),
        .i_timer2_period_match(ev[2]), .i_chan_capture(ev[4:3]),
        .i_chan_compare(ev[6:5]), .i_chan_pwm_fall(ev[8:7]));
    // strobe drops with a spare edge so back-to-back calls never clash
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [3:0] a);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 q = o_rdata;
        @(posedge i_clock);
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // whole run is about 110 cycles
    initial
    begin
        #10us;
        num_errors++;
        stop_test;
    end
    initial
    begin
        {i_nrst, i_wr, i_rd, i_timer2_ratio_one, i_global_interrupt_enable, i_addr, i_wdata} = '0;
        repeat (5) @(posedge i_clock);
        i_nrst <= 1'b1;
        for (int a = 0; a < 6; a++)
        begin
            rd(a[3:0]);
            chk(q, 8'h00);
        end
        // enables stay off here: flags must still latch
        foreach (rows[i])
        begin
            i_timer2_ratio_one <= rows[i].r1;
            wr(PIF_ADDR_MODE, {4'h0, rows[i].md});
            src_u.fire(rows[i].ev);
            rd(rows[i].ad);
            chk(q, rows[i].ex);
            wr(rows[i].ad, 8'h00);
        end
        wr(PIF_ADDR_TIMER, 8'hff);
        rd(PIF_ADDR_TIMER);
        chk(q, 8'h03);
        fork
            src_u.fire(9'h001);
            wr(PIF_ADDR_TIMER, 8'h00);
        join
        rd(PIF_ADDR_TIMER);
        chk(q, 8'h01);
        wr(PIF_ADDR_TIMER, 8'h00);
        rd(PIF_ADDR_TIMER);
        chk(q, 8'h00);
        rd(PIF_ADDR_STAT);
        wr(PIF_ADDR_MASK, 8'h01);
        rd(PIF_ADDR_MASK);
        chk(q, 8'h01);
        i_global_interrupt_enable <= 1'b1;
        src_u.fire(9'h002);
        #1 chk({7'h00, o_irq}, 8'h00);
        src_u.fire(9'h001);
        #1 chk({7'h00, o_irq}, 8'h01);
        i_global_interrupt_enable <= 1'b0;
        #1 chk({7'h00, o_irq}, 8'h00);
        i_global_interrupt_enable <= 1'b1;
        #1 chk({7'h00, o_irq}, 8'h01);
        rd(PIF_ADDR_TIMER);
        rd(PIF_ADDR_TIMER);
        chk(q, 8'h03);
        rd(PIF_ADDR_STAT);
        chk(q, 8'h03);
        #1 chk({7'h00, o_irq}, 8'h00);
        stop_test;
    end
endmodule // pif_flags_tb_top
